// *** src/cwp_pkg.sv ***
`default_nettype none

package cwp_pkg;

  localparam int unsigned ADDR_W = 28;
  localparam int unsigned DATA_W = 32;

  // Byte addresses of the register map
  localparam logic [27:0] CTRL_BASE          = 28'hFFFFC00;
  localparam logic [27:0] CHARGE_PUMP_ADDR   = 28'hFFFFC80;
  localparam logic [27:0] WP_MODE_ADDR       = 28'hFFFFCE4;
  localparam logic [27:0] WP_STATUS_ADDR     = 28'hFFFFCE8;
  localparam logic [27:0] PERIPH_CLK_ADDR    = 28'hFFFFD0C;
  localparam logic [27:0] IRQ_STATUS_ADDR    = 28'hFFFFD20;
  localparam logic [27:0] IRQ_MASK_ADDR      = 28'hFFFFD24;

  // Write protection mode fields
  localparam int unsigned PROT_ON_BIT        = 0;
  localparam int unsigned KEY_LSB            = 8;
  localparam int unsigned KEY_W              = 24;
  localparam logic [23:0] PROTECTION_KEY_VALUE = 24'h504D43;

  // Write protection status fields
  localparam int unsigned VIOL_FLAG_BIT      = 0;
  localparam int unsigned VIOL_OFF_LSB       = 8;
  localparam int unsigned VIOL_OFF_W         = 16;

  // Peripheral clock control fields
  localparam int unsigned SEL_LSB            = 0;
  localparam int unsigned SEL_W              = 6;
  localparam int unsigned CMD_BIT            = 12;
  localparam int unsigned DIV_LSB            = 16;
  localparam int unsigned DIV_W              = 2;
  localparam int unsigned EN_BIT             = 28;
  localparam logic [5:0]  SEL_FIRST          = 6'h02;
  localparam logic [5:0]  SEL_LAST           = 6'h1F;
  localparam int unsigned NUM_PERIPH         = 32;

  // Interrupt status / mask layout
  localparam int unsigned IRQ_W              = 2;
  localparam int unsigned IRQ_VIOL_BIT       = 0;
  localparam int unsigned IRQ_PCLK_BIT       = 1;

  // Reset values
  localparam logic        CHARGE_PUMP_RST    = 1'b0;
  localparam logic        PROT_ON_RST        = 1'b0;
  localparam logic [1:0]  DIV_RST            = 2'h0;
  localparam logic [1:0]  IRQ_MASK_RST       = 2'h0;

  // Divider state: count width covers divide by 8
  localparam int unsigned DIV_CNT_W          = 3;

endpackage

`default_nettype wire

// *** src/cwp_wr_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface cwp_wr_if;
  logic        wr_stb;
  logic [27:0] wr_addr;
  logic        prot_on;
  logic        blocked;
  logic [15:0] viol_off;

  modport ctrl  (output wr_stb, output wr_addr, output prot_on, input blocked, input viol_off);
  modport guard (input wr_stb, input wr_addr, input prot_on, output blocked, output viol_off);
endinterface

`default_nettype wire

// *** src/cwp_wr_guard.sv ***
`timescale 1ns/1ps
`default_nettype none

module cwp_wr_guard (
  cwp_wr_if.guard wr
);

  logic        is_protected;
  logic [27:0] rel_addr;

  // Registers covered by write protection
  assign is_protected = (wr.wr_addr == cwp_pkg::CHARGE_PUMP_ADDR) ||
                        (wr.wr_addr == cwp_pkg::PERIPH_CLK_ADDR);
  assign wr.blocked   = wr.wr_stb && wr.prot_on && is_protected;  // [R1] [R13]
  assign rel_addr     = wr.wr_addr - cwp_pkg::CTRL_BASE;
  assign wr.viol_off  = rel_addr[15:0];                           // [R6]

endmodule

`default_nettype wire

// *** src/cwp_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none

module cwp_clk_div #(
  parameter int unsigned CNT_W = 3
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic [1:0] div_i,
  output logic            tick_o
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last;

  // Terminal count for divide by 1, 2, 4 or 8
  always_comb begin
    unique case (div_i)
      2'h0: last = CNT_W'(0);
      2'h1: last = CNT_W'(1);
      2'h2: last = CNT_W'(3);
      2'h3: last = CNT_W'(7);
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (!en_i || cnt_r >= last) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // One master-clock-wide enable per divided period
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= en_i && (cnt_r >= last);  // [R9] [R10]
    end
  end

endmodule

`default_nettype wire

// *** src/cwp_clock_ctrl.sv ***
// What this block does
// (R1) Charge-pump register writable only while unprotected
// (R2) Key-qualified write of zero disables protection
// (R3) Key-qualified write of one enables protection
// (R4) Wrong key aborts; key reads zero
// (R5) Violation flag sticky until status read
// (R6) Violation offset captures blocked write address
// (R7) Status read clears the violation flag
// (R8) Selector picks peripheral two through thirty-one
// (R9) Divisor: master clock over 1,2,4,8
// (R10) Enable bit 28 gates peripheral clock
// (R11) Software programs charge-pump bit per PLL spec
// (R12) Command bit: read mode versus write mode
// (R13) Protected writes discarded, violation recorded
`timescale 1ns/1ps
`default_nettype none

module cwp_clock_ctrl #(
  parameter int unsigned NUM_PERIPH = 32
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [27:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o,
  output logic             charge_pump_current_bit_o,
  output logic             protection_on_o,
  output logic [NUM_PERIPH-1:0] periph_clk_en_o
);

  // Address decode
  logic hit_charge_pump;
  logic hit_wp_mode;
  logic hit_wp_status;
  logic hit_periph_clk;
  logic hit_irq_status;
  logic hit_irq_mask;

  assign hit_charge_pump = (addr_i == cwp_pkg::CHARGE_PUMP_ADDR);
  assign hit_wp_mode     = (addr_i == cwp_pkg::WP_MODE_ADDR);
  assign hit_wp_status   = (addr_i == cwp_pkg::WP_STATUS_ADDR);
  assign hit_periph_clk  = (addr_i == cwp_pkg::PERIPH_CLK_ADDR);
  assign hit_irq_status  = (addr_i == cwp_pkg::IRQ_STATUS_ADDR);
  assign hit_irq_mask    = (addr_i == cwp_pkg::IRQ_MASK_ADDR);

  // Write protection check
  cwp_wr_if wr_chk ();

  logic prot_on_r;

  assign wr_chk.wr_stb  = wr_i;
  assign wr_chk.wr_addr = addr_i;
  assign wr_chk.prot_on = prot_on_r;

  cwp_wr_guard u_guard (
    .wr (wr_chk.guard)
  );

  logic wr_allowed;
  assign wr_allowed = wr_i && !wr_chk.blocked;  // [R13]

  // Charge-pump current bit
  logic charge_pump_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      charge_pump_r <= cwp_pkg::CHARGE_PUMP_RST;
    end else if (wr_allowed && hit_charge_pump) begin  // [R1]
      charge_pump_r <= wdata_i[0];                     // [R11]
    end
  end

  assign charge_pump_current_bit_o = charge_pump_r;

  // Protection enable, updated only with the correct key
  logic [23:0] key_field;
  logic        key_ok;

  assign key_field = wdata_i[cwp_pkg::KEY_LSB +: cwp_pkg::KEY_W];
  assign key_ok    = (key_field == cwp_pkg::PROTECTION_KEY_VALUE);  // [R4]

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prot_on_r <= cwp_pkg::PROT_ON_RST;
    end else if (wr_i && hit_wp_mode && key_ok) begin
      // Zero turns protection off, one turns it on
      prot_on_r <= wdata_i[cwp_pkg::PROT_ON_BIT];  // [R2] [R3]
    end
  end

  assign protection_on_o = prot_on_r;

  // Violation flag and source offset
  logic        viol_flag_r;
  logic [15:0] viol_off_r;
  logic        viol_event;
  logic        wp_status_rd;

  assign viol_event   = wr_chk.blocked;               // [R13]
  assign wp_status_rd = rd_i && hit_wp_status;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      viol_flag_r <= 1'b0;
    end else if (viol_event) begin
      // A new violation wins over a clearing read
      viol_flag_r <= 1'b1;                            // [R5]
    end else if (wp_status_rd) begin
      viol_flag_r <= 1'b0;                            // [R7]
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      viol_off_r <= '0;
    end else if (viol_event) begin
      viol_off_r <= wr_chk.viol_off;                  // [R6]
    end
  end

  // Peripheral clock control fields of the current write
  logic [5:0] sel_field;
  logic [1:0] div_field;
  logic       en_field;
  logic       cmd_field;
  logic       sel_valid;

  assign sel_field = wdata_i[cwp_pkg::SEL_LSB +: cwp_pkg::SEL_W];
  assign div_field = wdata_i[cwp_pkg::DIV_LSB +: cwp_pkg::DIV_W];
  assign en_field  = wdata_i[cwp_pkg::EN_BIT];
  assign cmd_field = wdata_i[cwp_pkg::CMD_BIT];
  assign sel_valid = (sel_field >= cwp_pkg::SEL_FIRST) &&
                     (sel_field <= cwp_pkg::SEL_LAST);  // [R8]

  logic pclk_wr;
  logic pclk_apply;

  assign pclk_wr    = wr_allowed && hit_periph_clk && sel_valid;
  assign pclk_apply = pclk_wr && cmd_field;             // [R12]

  // Per-peripheral settings
  logic [1:0] div_r [NUM_PERIPH];
  logic       en_r  [NUM_PERIPH];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_PERIPH; i++) begin
        div_r[i] <= cwp_pkg::DIV_RST;
      end
    end else if (pclk_apply) begin
      div_r[sel_field[4:0]] <= div_field;               // [R9]
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_PERIPH; i++) begin
        en_r[i] <= 1'b0;
      end
    end else if (pclk_apply) begin
      en_r[sel_field[4:0]] <= en_field;                 // [R10]
    end
  end

  // Read mode only moves the selector used for readback
  logic [4:0] sel_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_r <= cwp_pkg::SEL_FIRST[4:0];
    end else if (pclk_wr) begin
      sel_r <= sel_field[4:0];                          // [R12]
    end
  end

  // Divided clock enables, one per selectable peripheral
  assign periph_clk_en_o[0] = 1'b0;
  assign periph_clk_en_o[1] = 1'b0;

  generate
    for (genvar g = 2; g < NUM_PERIPH; g++) begin : g_div
      cwp_clk_div #(
        .CNT_W (cwp_pkg::DIV_CNT_W)
      ) u_div (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .en_i   (en_r[g]),
        .div_i  (div_r[g]),
        .tick_o (periph_clk_en_o[g])
      );
    end
  endgenerate

  // Interrupt status: sticky, cleared by reading it
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_set;
  logic       irq_stat_rd;

  assign irq_set[cwp_pkg::IRQ_VIOL_BIT] = viol_event;
  assign irq_set[cwp_pkg::IRQ_PCLK_BIT] = pclk_apply;
  assign irq_stat_rd = rd_i && hit_irq_status;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (irq_stat_rd) begin
      // Events in the clearing cycle survive
      irq_stat_r <= irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_r <= cwp_pkg::IRQ_MASK_RST;
    end else if (wr_i && hit_irq_mask) begin
      irq_mask_r <= wdata_i[cwp_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Read data, valid only in the cycle after the read strobe
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;

  always_comb begin
    rdata_nxt = '0;
    if (rd_i) begin
      if (hit_charge_pump) begin
        rdata_nxt[0] = charge_pump_r;
      end else if (hit_wp_mode) begin
        // Key field reads as zero
        rdata_nxt[cwp_pkg::PROT_ON_BIT] = prot_on_r;  // [R4]
      end else if (hit_wp_status) begin
        rdata_nxt[cwp_pkg::VIOL_FLAG_BIT] = viol_flag_r;
        rdata_nxt[cwp_pkg::VIOL_OFF_LSB +: cwp_pkg::VIOL_OFF_W] = viol_off_r;  // [R6]
      end else if (hit_periph_clk) begin
        rdata_nxt[cwp_pkg::SEL_LSB +: cwp_pkg::SEL_W] = {1'b0, sel_r};
        rdata_nxt[cwp_pkg::DIV_LSB +: cwp_pkg::DIV_W] = div_r[sel_r];
        rdata_nxt[cwp_pkg::EN_BIT] = en_r[sel_r];
      end else if (hit_irq_status) begin
        rdata_nxt[cwp_pkg::IRQ_W-1:0] = irq_stat_r;
      end else if (hit_irq_mask) begin
        rdata_nxt[cwp_pkg::IRQ_W-1:0] = irq_mask_r;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

endmodule

`default_nettype wire

// *** testbench/cwp_clock_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module cwp_clock_ctrl_chk #(
  parameter int unsigned NUM_PERIPH = 32
) (
  input wire logic                  mclk_i,
  input wire logic                  rst_i,
  input wire logic [27:0]           addr_i,
  input wire logic [31:0]           wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [31:0]           rdata_o,
  input wire logic                  irq_o,
  input wire logic                  charge_pump_current_bit_o,
  input wire logic                  protection_on_o,
  input wire logic [NUM_PERIPH-1:0] periph_clk_en_o
);
  wire logic cp_wr  = wr_i && addr_i == cwp_pkg::CHARGE_PUMP_ADDR;
  wire logic wp_wr  = wr_i && addr_i == cwp_pkg::WP_MODE_ADDR;
  wire logic st_rd  = rd_i && addr_i == cwp_pkg::WP_STATUS_ADDR;
  wire logic key_ok = wdata_i[31:8] == cwp_pkg::PROTECTION_KEY_VALUE;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not idle");
  chk_key_mode: assert property (wp_wr && key_ok |=> protection_on_o == $past(wdata_i[0]))
    else $error("keyed mode write not applied");
  chk_bad_key: assert property (wp_wr && !key_ok |=> $stable(protection_on_o))
    else $error("wrong key changed protection");
  chk_prot_hold: assert property (!wp_wr |=> $stable(protection_on_o))
    else $error("protection changed without mode write");
  chk_cp_write: assert property (cp_wr && !protection_on_o |=> charge_pump_current_bit_o == $past(wdata_i[0]))
    else $error("charge pump write lost");
  chk_cp_blocked: assert property (cp_wr && protection_on_o |=> $stable(charge_pump_current_bit_o))
    else $error("protected charge pump write applied");
  chk_low_sel: assert property (periph_clk_en_o[1:0] == 2'h0)
    else $error("reserved peripheral clock active");
  chk_viol_capture: assert property (cp_wr && protection_on_o ##1 !wr_i && !st_rd ##1 st_rd
    |=> rdata_o[0] && rdata_o[23:8] == 16'h0080)
    else $error("violation not reported");
  chk_status_clear: assert property (st_rd ##1 !wr_i ##1 st_rd |=> !rdata_o[0])
    else $error("status read did not clear flag");
  cover property (cp_wr && protection_on_o);
  cover property (wp_wr && !key_ok);
  cover property (irq_o);
endmodule
bind cwp_clock_ctrl cwp_clock_ctrl_chk #(.NUM_PERIPH(NUM_PERIPH)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .charge_pump_current_bit_o(charge_pump_current_bit_o), .protection_on_o(protection_on_o),
  .periph_clk_en_o(periph_clk_en_o));
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk_i  = 1'b0;
  logic        rst_i   = 1'b1;
  logic [27:0] addr_i  = 28'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [31:0] rdata_o;
  logic        irq_o;
  logic        cp_o;
  logic        prot_o;
  logic [31:0] pclk_o;
  int          errors   = 0;
  int          compares = 0;
  always #2.5 mclk_i = ~mclk_i;
  cwp_clock_ctrl uut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .charge_pump_current_bit_o(cp_o),
    .protection_on_o(prot_o), .periph_clk_en_o(pclk_o));
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [27:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [27:0] a, input logic [31:0] exp, input string name);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check(name, exp, rdata_o);
  endtask
  // Counts enable pulses of one peripheral over a 32-cycle window
  task automatic pulses(input int idx, input int exp, input string name);
    int n;
    n = 0;
    repeat (10) @(posedge mclk_i);
    repeat (32) begin
      @(posedge mclk_i);
      #1;
      if (pclk_o[idx] === 1'b1) n++;
    end
    check(name, 32'(exp), 32'(n));
  endtask
  task automatic t_reset;
    check("reset outputs", 32'h0, {cp_o, prot_o, irq_o, pclk_o[28:0]});
    rd(cwp_pkg::CHARGE_PUMP_ADDR, 32'h0, "charge pump reset");
    rd(cwp_pkg::WP_MODE_ADDR, 32'h0, "mode reset");
    rd(cwp_pkg::IRQ_MASK_ADDR, 32'h0, "mask reset");
    rd(cwp_pkg::PERIPH_CLK_ADDR, 32'h2, "periph reset");
    rd(28'hFFFFC04, 32'h0, "unmapped read");
  endtask
  task automatic t_protect;
    wr(cwp_pkg::CHARGE_PUMP_ADDR, 32'h1);
    rd(cwp_pkg::CHARGE_PUMP_ADDR, 32'h1, "charge pump open");
    wr(cwp_pkg::WP_MODE_ADDR, 32'h1);
    check("unkeyed enable", 32'h0, 32'(prot_o));
    wr(cwp_pkg::WP_MODE_ADDR, 32'h504D4301);
    check("keyed enable", 32'h1, 32'(prot_o));
    rd(cwp_pkg::WP_MODE_ADDR, 32'h1, "key reads zero");
    wr(cwp_pkg::IRQ_MASK_ADDR, 32'h1);
    wr(cwp_pkg::CHARGE_PUMP_ADDR, 32'h0);
    check("blocked write", 32'h1, 32'(cp_o));
    check("irq raised", 32'h1, 32'(irq_o));
    rd(cwp_pkg::WP_STATUS_ADDR, 32'h8001, "violation");
    rd(cwp_pkg::WP_STATUS_ADDR, 32'h8000, "violation cleared");
    rd(cwp_pkg::IRQ_STATUS_ADDR, 32'h1, "irq status");
    check("irq cleared", 32'h0, 32'(irq_o));
    wr(cwp_pkg::PERIPH_CLK_ADDR, 32'h10001005);
    rd(cwp_pkg::WP_STATUS_ADDR, 32'h10C01, "periph violation");
    wr(cwp_pkg::IRQ_MASK_ADDR, 32'h0);
    rd(cwp_pkg::IRQ_STATUS_ADDR, 32'h1, "irq status again");
    wr(cwp_pkg::WP_MODE_ADDR, 32'h12345600);
    check("wrong key", 32'h1, 32'(prot_o));
    rd(cwp_pkg::WP_STATUS_ADDR, 32'h10C00, "wrong key silent");
    wr(cwp_pkg::WP_MODE_ADDR, 32'h504D4300);
    check("keyed disable", 32'h0, 32'(prot_o));
  endtask
  task automatic t_periph;
    for (int d = 0; d < 4; d++) begin
      wr(cwp_pkg::PERIPH_CLK_ADDR, 32'h10001005 | (32'(d) << 16));
      rd(cwp_pkg::PERIPH_CLK_ADDR, 32'h10000005 | (32'(d) << 16), "periph readback");
      pulses(5, 32 >> d, "divided clock");
    end
    wr(cwp_pkg::IRQ_MASK_ADDR, 32'h2);
    check("apply irq", 32'h1, 32'(irq_o));
    rd(cwp_pkg::IRQ_STATUS_ADDR, 32'h2, "apply status");
    check("apply irq cleared", 32'h0, 32'(irq_o));
    wr(cwp_pkg::PERIPH_CLK_ADDR, 32'h00000005);
    pulses(5, 4, "read mode keeps");
    wr(cwp_pkg::PERIPH_CLK_ADDR, 32'h10001001);
    pulses(1, 0, "selector one");
    rd(cwp_pkg::PERIPH_CLK_ADDR, 32'h10030005, "selector one ignored");
    wr(cwp_pkg::PERIPH_CLK_ADDR, 32'h1000101F);
    pulses(31, 32, "selector last");
    wr(cwp_pkg::PERIPH_CLK_ADDR, 32'h10031002);
    pulses(2, 4, "selector first");
    wr(cwp_pkg::PERIPH_CLK_ADDR, 32'h10001022);
    rd(cwp_pkg::PERIPH_CLK_ADDR, 32'h10030002, "selector wide ignored");
    wr(cwp_pkg::PERIPH_CLK_ADDR, 32'h00001005);
    pulses(5, 0, "disabled clock");
  endtask
  task automatic print_verdict;
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    t_reset();
    t_protect();
    t_periph();
    print_verdict();
  end
endmodule
`default_nettype wire
